// ===== ssrx_checker.sv
`timescale 1ns/1ns
`default_nettype none
module ssrx_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic serial_clock_pin_o,
  input wire logic serial_clock_pin_oe,
  input wire logic serial_out_pin,
  input wire logic serial_irq
);
  logic rd_st;
  logic rd_rx;
  logic stop_wr;
  // Status reads, buffer reads and force-stop writes in their access phase.
  assign rd_st = psel && penable && !pwrite && paddr == ssrx_pkg::status_off;
  assign rd_rx = psel && penable && !pwrite && paddr == ssrx_pkg::rxbuf_off;
  assign stop_wr = psel && penable && pwrite && paddr == ssrx_pkg::ctrl_off && pwdata[6];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_irq_pulse: assert property (serial_irq |=> !serial_irq)
    else $error("irq longer than one cycle");
  a_idle_clock_high: assert property (!serial_clock_pin_oe |-> serial_clock_pin_o)
    else $error("undriven clock not high");
  a_stop_parks: assert property (stop_wr |-> ##[1:3] (serial_out_pin && serial_clock_pin_o) [*4])
    else $error("pins not idle after force stop");
  a_rx_upper_zero: assert property (rd_rx |-> prdata[31:8] == 24'h0)
    else $error("receive data wider than a byte");
  a_underrun_high: assert property (rd_st && prdata[3] |-> serial_out_pin)
    else $error("output low during underrun");
  a_idle_out_high: assert property (rd_st && !prdata[7] |-> serial_out_pin)
    else $error("output low while stopped");
  a_overrun_quiet: assert property (rd_st && prdata[2] |-> !serial_irq [*2])
    else $error("irq during overrun");
  a_partial_active: assert property (rd_st && prdata[6] |-> prdata[7])
    else $error("partial flag without active flag");
endmodule : ssrx_checker
bind ssrx_core ssrx_checker chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .serial_clock_pin_o, .serial_clock_pin_oe, .serial_out_pin, .serial_irq);
`default_nettype wire

// ===== ssrx_core.sv
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - External clock missing tx data sets underrun.
// - Underrun holds output high until status clear or force stop.
// - Force stop clears run, status, buffers.
// - Mode code one selects receive only.
// - Active flag sets on next falling edge.
// - Receive samples input on rising edges.
// - Partial flag high from first to eighth fall.
// - Full byte copies to buffer, raises irq.
// - Reading receive buffer clears full flag.
// - Internal clock parks high until buffer read.
// - Unread buffer at byte end sets overrun.
// - Clearing run finishes current byte first.
// - Overrun discards new bits, keeps contents.
// - After overrun, second read returns shift data.
// - Clearing overrun clears full flag only after a buffer read.
// - Overrun does not stop transfers; clearing run stops them.
// - Uncorrected overrun blocks further interrupts.
// - Combined mode drives on fall, samples rise.
// - Combined: empty on rise, irq on receive.
// - Combined internal parks until read and write.
// - Combined underrun irq waits for full byte.
// - Order select zero MSB, one LSB first.
module ssrx_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_clock_pin_i,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic serial_irq
);
  logic [7:0] ctrl_reg;
  logic [15:0] div_reg;
  logic [7:0] tx_holding_buffer;
  logic [7:0] rx_holding_buffer;
  logic [7:0] shift_reg;
  logic [3:0] bitcnt_reg;
  logic transfer_active_flag, partial_byte_flag, tx_empty_flag, rx_full_flag;
  logic tx_underrun_flag, rx_overrun_flag;
  logic irq_pend_reg, shadow_reg;
  logic [2:0] sck_sync_reg, sin_sync_reg;
  logic [15:0] div_cnt_reg;
  logic sck_out_reg, tx_loaded_reg, rx_read_reg;
  logic wr_acc, rd_acc, force_stop, ext_clk, lsb_first;
  logic fall, rise, byte_done, parked, clk_level;
  logic [1:0] mode;
  logic tx_en, rx_en;

  // Bus decode and control fields.
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign mode = ctrl_reg[ssrx_pkg::ctrl_mode_hi:ssrx_pkg::ctrl_mode_lo];
  assign ext_clk = ctrl_reg[ssrx_pkg::ctrl_ext_bit];
  assign lsb_first = ctrl_reg[ssrx_pkg::ctrl_order_bit];
  assign tx_en = (mode == ssrx_pkg::mode_tx) || (mode == ssrx_pkg::mode_txrx);
  assign rx_en = (mode == ssrx_pkg::mode_rx) || (mode == ssrx_pkg::mode_txrx);
  assign force_stop = wr_acc && (paddr == ssrx_pkg::ctrl_off) &&
                      pwdata[ssrx_pkg::ctrl_stop_bit];

  // Synchronise the external clock and data pins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_sync_reg <= 3'h7;
      sin_sync_reg <= 3'h7;
    end else begin
      sck_sync_reg <= {sck_sync_reg[1:0], serial_clock_pin_i};
      sin_sync_reg <= {sin_sync_reg[1:0], serial_in_pin};
    end
  end

  // Internal clock pauses high while waiting for buffer service.
  // receive auto wait
  always_comb begin
    parked = 1'b0;
    if (mode == ssrx_pkg::mode_rx)
      parked = rx_full_flag;
    else if (mode == ssrx_pkg::mode_txrx)
      parked = rx_full_flag || tx_empty_flag;
    else
      parked = tx_empty_flag;
  end

  // Internal clock divider; halts high between bytes when parked or stopped.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_reg <= 16'h0000;
      sck_out_reg <= 1'b1;
    end else if (ext_clk || force_stop) begin
      div_cnt_reg <= 16'h0000;
      sck_out_reg <= 1'b1;
    end else if (sck_out_reg && bitcnt_reg == 4'h0 &&
                 (parked || !ctrl_reg[ssrx_pkg::ctrl_run_bit])) begin
      div_cnt_reg <= 16'h0000;
    end else if (div_cnt_reg >= div_reg) begin
      div_cnt_reg <= 16'h0000;
      sck_out_reg <= !sck_out_reg;
    end else begin
      div_cnt_reg <= div_cnt_reg + 16'h0001;
    end
  end

  // Edge detection on the serial clock level seen by the shifter.
  assign clk_level = ext_clk ? sck_sync_reg[1] : sck_out_reg;
  logic clk_prev_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      clk_prev_reg <= 1'b1;
    else
      clk_prev_reg <= clk_level;
  end
  assign fall = clk_prev_reg && !clk_level;
  assign rise = !clk_prev_reg && clk_level;
  assign byte_done = rise && (bitcnt_reg == ssrx_pkg::bits_per_byte);

  // Control and divider registers.
  // run cleared
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= ssrx_pkg::ctrl_reset;
      div_reg <= ssrx_pkg::div_reset;
    end else if (force_stop) begin
      ctrl_reg <= {1'b0, 1'b0, pwdata[5:0]};
    end else if (wr_acc && paddr == ssrx_pkg::ctrl_off) begin
      ctrl_reg <= {pwdata[7], 1'b0, pwdata[5:0]};
    end else if (wr_acc && paddr == ssrx_pkg::div_off) begin
      div_reg <= pwdata[15:0];
    end
  end

  // Bit counter, active and partial flags.
  // active on fall
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bitcnt_reg <= 4'h0;
      transfer_active_flag <= 1'b0;
      partial_byte_flag <= 1'b0;
    end else if (force_stop) begin
      bitcnt_reg <= 4'h0;
      transfer_active_flag <= 1'b0;
      partial_byte_flag <= 1'b0;
    end else if (fall) begin
      if (bitcnt_reg == 4'h0 && ctrl_reg[ssrx_pkg::ctrl_run_bit]) begin
        bitcnt_reg <= 4'h1;
        transfer_active_flag <= 1'b1;
        partial_byte_flag <= 1'b1;
      end else if (bitcnt_reg != 4'h0 && bitcnt_reg < 4'h7) begin
        bitcnt_reg <= bitcnt_reg + 4'h1;
      end else if (bitcnt_reg == 4'h7) begin
        bitcnt_reg <= ssrx_pkg::bits_per_byte;
        partial_byte_flag <= 1'b0;
      end
    end else if (byte_done) begin
      bitcnt_reg <= 4'h0;
      if (!ctrl_reg[ssrx_pkg::ctrl_run_bit])
        transfer_active_flag <= 1'b0;
    end else if (bitcnt_reg == 4'h0 && !ctrl_reg[ssrx_pkg::ctrl_run_bit]) begin
      transfer_active_flag <= 1'b0;
    end
  end

  // Transmit path: load on first fall, shift on falls, underrun detection.
  // underrun set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_holding_buffer <= 8'h00;
      tx_empty_flag <= 1'b1;
      tx_underrun_flag <= 1'b0;
      tx_loaded_reg <= 1'b0;
      serial_out_pin <= 1'b1;
    end else if (force_stop) begin
      tx_holding_buffer <= 8'h00;
      tx_empty_flag <= 1'b1;
      tx_underrun_flag <= 1'b0;
      tx_loaded_reg <= 1'b0;
      serial_out_pin <= 1'b1;
    end else begin
      if (wr_acc && paddr == ssrx_pkg::txbuf_off) begin
        tx_holding_buffer <= pwdata[7:0];
        tx_empty_flag <= 1'b0;
      end
      if (wr_acc && paddr == ssrx_pkg::status_off &&
          !pwdata[ssrx_pkg::st_tx_underrun_flag_bit])
        tx_underrun_flag <= 1'b0;
      if (tx_en && fall && bitcnt_reg == 4'h0 && ctrl_reg[ssrx_pkg::ctrl_run_bit]) begin
        if (tx_empty_flag)
          tx_underrun_flag <= 1'b1;
        else
          tx_loaded_reg <= 1'b1;
      end
      if (tx_loaded_reg && rise) begin
        tx_empty_flag <= 1'b1;
        tx_loaded_reg <= 1'b0;
      end
      // The pin is driven here directly so the new bit stands well before the next rise.
      if (!tx_en || tx_underrun_flag || bitcnt_reg == 4'h0 && !fall)
        serial_out_pin <= 1'b1;
      else if (fall && bitcnt_reg != ssrx_pkg::bits_per_byte)
        serial_out_pin <= lsb_first ? tx_bit(bitcnt_reg, 1'b1) : tx_bit(bitcnt_reg, 1'b0);
    end
  end

  // Selects the bit to send for the next fall.
  function automatic logic tx_bit(input logic [3:0] cnt, input logic lsb);
    logic [2:0] idx;
    // In combined mode the receive shifting moves the next bit to the end.
    idx = rx_en ? (lsb ? 3'h0 : 3'h7) : (lsb ? cnt[2:0] : 3'h7 - cnt[2:0]);
    tx_bit = (cnt == 4'h0 && tx_empty_flag) ? 1'b1 :
             ((cnt == 4'h0) ? tx_holding_buffer[idx] : shift_reg[idx]);
  endfunction : tx_bit

  // Receive path, buffer, full and overrun flags.
  // sample on rise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_reg <= 8'h00;
      rx_holding_buffer <= 8'h00;
      rx_full_flag <= 1'b0;
      rx_overrun_flag <= 1'b0;
      shadow_reg <= 1'b0;
      rx_read_reg <= 1'b0;
    end else if (force_stop) begin
      shift_reg <= 8'h00;
      rx_holding_buffer <= 8'h00;
      rx_full_flag <= 1'b0;
      rx_overrun_flag <= 1'b0;
      shadow_reg <= 1'b0;
      rx_read_reg <= 1'b0;
    end else begin
      if (tx_en && fall && bitcnt_reg == 4'h0 && !tx_empty_flag && !rx_overrun_flag)
        shift_reg <= tx_holding_buffer;
      if (rx_en && rise && bitcnt_reg != 4'h0 && !rx_overrun_flag) begin
        if (lsb_first)
          shift_reg <= {sin_sync_reg[1], shift_reg[7:1]};
        else
          shift_reg <= {shift_reg[6:0], sin_sync_reg[1]};
      end
      if (rd_acc && paddr == ssrx_pkg::rxbuf_off) begin
        rx_full_flag <= 1'b0;
        if (rx_overrun_flag) begin
          if (shadow_reg)
            rx_holding_buffer <= shift_reg;
          shadow_reg <= 1'b1;
          rx_read_reg <= 1'b1;
        end
      end
      if (wr_acc && paddr == ssrx_pkg::status_off &&
          !pwdata[ssrx_pkg::st_rx_overrun_flag_bit]) begin
        rx_overrun_flag <= 1'b0;
        shadow_reg <= 1'b0;
        if (rx_read_reg)
          rx_full_flag <= 1'b0;
        rx_read_reg <= 1'b0;
      end
      if (rx_en && byte_done && !rx_overrun_flag) begin
        if (rx_full_flag && ext_clk && !(rd_acc && paddr == ssrx_pkg::rxbuf_off)) begin
          rx_overrun_flag <= 1'b1;
        end else begin
          rx_holding_buffer <= lsb_first ? {sin_sync_reg[1], shift_reg[7:1]} :
                                           {shift_reg[6:0], sin_sync_reg[1]};
          rx_full_flag <= 1'b1;
        end
      end
    end
  end

  // Interrupt pulse generation.
  // blocked by overrun
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_irq <= 1'b0;
      irq_pend_reg <= 1'b0;
    end else begin
      serial_irq <= 1'b0;
      if (force_stop) begin
        irq_pend_reg <= 1'b0;
      end else if (mode == ssrx_pkg::mode_tx) begin
        if (tx_loaded_reg && rise)
          irq_pend_reg <= 1'b1;
        // Underrun raises the request on the fall after the shift start.
        if ((irq_pend_reg && fall) || (tx_underrun_flag && bitcnt_reg == 4'h1 && fall)) begin
          serial_irq <= 1'b1;
          irq_pend_reg <= 1'b0;
        end
      end else if (rx_en && byte_done && !rx_overrun_flag) begin
        serial_irq <= 1'b1;
      end
    end
  end

  // APB read data and fixed answers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        ssrx_pkg::ctrl_off: prdata <= {24'h000000, ctrl_reg};
        ssrx_pkg::status_off: prdata <= {24'h000000, transfer_active_flag,
          partial_byte_flag, tx_empty_flag, rx_full_flag, tx_underrun_flag,
          rx_overrun_flag, 2'h0};
        ssrx_pkg::rxbuf_off: prdata <= {24'h000000, (rx_overrun_flag && shadow_reg) ?
                                        shift_reg : rx_holding_buffer};
        ssrx_pkg::div_off: prdata <= {16'h0000, div_reg};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Pin drivers from flops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_clock_pin_o <= 1'b1;
      serial_clock_pin_oe <= 1'b0;
      pslverr <= 1'b0;
      pready <= 1'b1;
    end else begin
      serial_clock_pin_o <= sck_out_reg;
      serial_clock_pin_oe <= !ext_clk;
      pslverr <= psel && !penable && paddr > ssrx_pkg::div_off;
      pready <= 1'b1;
    end
  end
endmodule : ssrx_core
`default_nettype wire

// ===== ssrx_core_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module ssrx_core_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic lsb = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, sck_o, sck_oe, so, irq, si, drv, sck;
  int fail_count = 0;
  int n_tests = 0;
  int irqs = 0;
  int falls = 0;
  int cyc = 0;
  logic [31:0] eq[$];
  logic [31:0] mq[$];
  ssrx_core DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_clock_pin_i(sck), .serial_clock_pin_o(sck_o),
    .serial_clock_pin_oe(sck_oe), .serial_in_pin(si), .serial_out_pin(so), .serial_irq(irq));
  ssrx_peer peer (.pclk(pclk), .sck(sck), .so(so), .lsb(lsb), .si(si), .drv(drv));
  // Clock, and the level of the shared serial clock wire.
  initial forever #10 pclk = ~pclk;
  assign sck = sck_oe ? sck_o : drv;
  task automatic check(input string w, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", w, exp, seen);
    end
  endtask : check
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up
  // One APB transfer; it waits for pready and leaves one idle cycle.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    eq.push_back(e & m);
    mq.push_back(m);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic st(input logic [31:0] e, input logic [31:0] m);
    rd(ssrx_pkg::status_off, e, m);
  endtask : st
  task automatic rb(input logic [7:0] e);
    rd(ssrx_pkg::rxbuf_off, {24'h0, e}, 32'hffffffff);
  endtask : rb
  task automatic wc(input logic r, input logic [1:0] m, input logic e);
    apb(1'b1, ssrx_pkg::ctrl_off, {24'h0, r, 1'b0, m, lsb, 2'h0, e});
  endtask : wc
  // Completed reads are compared with the oldest note.
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready === 1'b1 && mq.size() > 0) begin
      check("read data", prdata & mq.pop_front(), eq.pop_front());
    end
    if (psel && penable && pready === 1'b1) begin
      check("slave error", {31'h0, pslverr}, {31'h0, paddr > ssrx_pkg::div_off});
    end
  end
  // Interrupt and clock-fall counters, and the hang limit.
  always @(posedge pclk) begin
    cyc++;
    if (irq === 1'b1) irqs++;
    if (cyc == 30000) begin
      fail_count++;
      wrap_up();
    end
  end
  always @(negedge sck) falls++;
  initial begin
    logic [7:0] a, b;
    int n;
    void'($urandom(56877));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(ssrx_pkg::ctrl_off, 32'h0, 32'hff);
    st(32'h20, 32'hff);
    rd(8'h14, 32'h0, 32'hffffffff);
    // Receive on the external clock in both bit orders.
    for (int o = 0; o < 2; o++) begin
      lsb = o[0];
      a = 8'($urandom);
      peer.load(a);
      wc(1'b1, ssrx_pkg::mode_rx, 1'b1);
      st(32'h0, 32'h80);
      n = irqs;
      peer.pulses(3);
      st(32'hc0, 32'hc0);
      peer.pulses(5);
      check("irq count", irqs, n + 1);
      st(32'h90, 32'hd0);
      rb(a);
      st(32'h0, 32'h10);
      apb(1'b1, ssrx_pkg::ctrl_off, 32'h40);
    end
    // Overrun: second byte unread, third byte dropped, then stop by run bit.
    lsb = 1'b0;
    a = 8'($urandom);
    b = ~a;
    wc(1'b1, ssrx_pkg::mode_rx, 1'b1);
    n = irqs;
    peer.load(a);
    peer.pulses(8);
    peer.load(b);
    peer.pulses(8);
    st(32'h14, 32'h14);
    check("irq count", irqs, n + 2);
    peer.load(a ^ 8'h5a);
    peer.pulses(8);
    wc(1'b0, ssrx_pkg::mode_rx, 1'b1);
    rb(a);
    rb(b);
    peer.pulses(8);
    check("irq count", irqs, n + 2);
    st(32'h04, 32'h84);
    apb(1'b1, ssrx_pkg::status_off, 32'h0);
    st(32'h0, 32'h14);
    // Transmit underrun on the external clock.
    wc(1'b1, ssrx_pkg::mode_tx, 1'b1);
    n = irqs;
    peer.pulses(1);
    st(32'h08, 32'h08);
    check("serial out", {31'h0, so}, 32'h1);
    check("irq count", irqs, n);
    peer.pulses(1);
    check("irq count", irqs, n + 1);
    apb(1'b1, ssrx_pkg::ctrl_off, 32'h40);
    st(32'h20, 32'hff);
    // Combined mode on the external clock, then an underrun in it.
    lsb = 1'($urandom);
    a = 8'($urandom);
    b = 8'($urandom);
    apb(1'b1, ssrx_pkg::txbuf_off, {24'h0, a});
    wc(1'b1, ssrx_pkg::mode_txrx, 1'b1);
    peer.load(b);
    n = irqs;
    peer.pulses(8);
    check("far byte", {24'h0, peer.rxd}, {24'h0, a});
    check("irq count", irqs, n + 1);
    st(32'h30, 32'h38);
    rb(b);
    peer.pulses(1);
    st(32'h08, 32'h08);
    check("irq count", irqs, n + 1);
    peer.pulses(7);
    check("irq count", irqs, n + 2);
    apb(1'b1, ssrx_pkg::ctrl_off, 32'h40);
    // Combined mode on the internal clock with auto-wait.
    lsb = 1'b0;
    apb(1'b1, ssrx_pkg::txbuf_off, {24'h0, b});
    peer.load(a);
    n = irqs;
    wc(1'b1, ssrx_pkg::mode_txrx, 1'b0);
    for (int i = 0; i < 2000 && irqs == n; i++) @(posedge pclk);
    check("far byte", {24'h0, peer.rxd}, {24'h0, b});
    rb(a);
    n = falls;
    repeat (60) @(posedge pclk);
    check("clock falls", falls, n);
    apb(1'b1, ssrx_pkg::txbuf_off, {24'h0, a});
    repeat (20) @(posedge pclk);
    check("clock resumed", {31'h0, falls != n}, 32'h1);
    apb(1'b1, ssrx_pkg::ctrl_off, 32'h40);
    st(32'h20, 32'hff);
    rd(ssrx_pkg::ctrl_off, 32'h0, 32'hff);
    rb(8'h00);
    repeat (4) @(posedge pclk);
    wrap_up();
  end
endmodule : ssrx_core_tb_top
`default_nettype wire

// ===== ssrx_peer.sv
`timescale 1ns/1ns
`default_nettype none
module ssrx_peer (
  input wire logic pclk,
  input wire logic sck,
  input wire logic so,
  input wire logic lsb,
  output logic si,
  output logic drv
);
  logic [7:0] txd = 8'h00;
  logic [7:0] rxd = 8'h00;
  logic [2:0] k = 3'h0;
  initial si = 1'b1;
  initial drv = 1'b1;
  // Presents a new byte from its first bit on.
  task automatic load(input logic [7:0] d);
    txd = d;
    k = 3'h0;
  endtask : load
  // Drives n clock pulses of 160 ns, then lets the line go stale.
  task automatic pulses(input int n);
    repeat (n) begin
      repeat (4) @(posedge pclk);
      drv <= 1'b0;
      repeat (4) @(posedge pclk);
      drv <= 1'b1;
    end
    repeat (8) @(posedge pclk);
    si <= ~si;
  endtask : pulses
  always @(negedge sck) si <= lsb ? txd[k] : txd[3'h7 - k];
  always @(posedge sck) begin
    rxd <= lsb ? {so, rxd[7:1]} : {rxd[6:0], so};
    k <= k + 3'h1;
  end
endmodule : ssrx_peer
`default_nettype wire

// ===== ssrx_pkg.sv
package ssrx_pkg;
  // Register byte offsets on the APB.
  localparam logic [7:0] ctrl_off = 8'h00;
  localparam logic [7:0] status_off = 8'h04;
  localparam logic [7:0] rxbuf_off = 8'h08;
  localparam logic [7:0] txbuf_off = 8'h0c;
  localparam logic [7:0] div_off = 8'h10;
  // Control field positions.
  localparam int ctrl_run_bit = 7;
  localparam int ctrl_stop_bit = 6;
  localparam int ctrl_mode_hi = 5;
  localparam int ctrl_mode_lo = 4;
  localparam int ctrl_order_bit = 3;
  localparam int ctrl_ext_bit = 0;
  // Status field positions.
  localparam int st_active_bit = 7;
  localparam int st_partial_bit = 6;
  localparam int st_txe_bit = 5;
  localparam int st_rxf_bit = 4;
  localparam int st_tx_underrun_flag_bit = 3;
  localparam int st_rx_overrun_flag_bit = 2;
  // Transfer mode codes.
  localparam logic [1:0] mode_tx = 2'h0;
  localparam logic [1:0] mode_rx = 2'h1;
  localparam logic [1:0] mode_txrx = 2'h2;
  // Reset values and bits per byte.
  localparam logic [7:0] ctrl_reset = 8'h00;
  localparam logic [15:0] div_reset = 16'h0004;
  localparam logic [3:0] bits_per_byte = 4'h8;
endpackage : ssrx_pkg
